// ---- rtl/scr_defs.vh ----
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// Register offsets
`define SCR_ADDR_OWN_LOCK 8'h00
`define SCR_ADDR_PEER 8'h01
`define SCR_ADDR_SPREAD_AUDIO 8'h02
`define SCR_ADDR_CAL_DIV 8'h03
`define SCR_ADDR_LOCK_LAST 8'h1f

// Field positions
`define SCR_OWN_ADDR_MSB 7
`define SCR_OWN_ADDR_LSB 1
`define SCR_LOCK_BIT 0
`define SCR_SPREAD_MSB 7
`define SCR_SPREAD_LSB 5
`define SCR_AUDIO_BIT 4
`define SCR_PIXEL_MSB 3
`define SCR_PIXEL_LSB 2
`define SCR_RATE_MSB 1
`define SCR_RATE_LSB 0
`define SCR_CAL_MSB 7
`define SCR_CAL_LSB 6
`define SCR_DIV_MSB 5
`define SCR_DIV_LSB 0

// Reset values
`define SCR_OWN_ADDR_RST 7'h40
`define SCR_LOCK_RST 1'b0
`define SCR_PEER_ADDR_RST 7'h48
`define SCR_AUDIO_RST 1'b1
`define SCR_PIXEL_RST 2'h3
`define SCR_RATE_RST 2'h3
`define SCR_CAL_RST 2'h0
`define SCR_DIV_RST 6'h00
`define SCR_SPREAD_OFF 3'h0
`define SCR_SPREAD_HALF 3'h1

// Range selector and calibration interval codes
`define SCR_RANGE_AUTO 2'h3
`define SCR_CAL_ONCE 2'h0
`define SCR_CAL_2MS 2'h1
`define SCR_CAL_16MS 2'h2
`define SCR_CAL_256MS 2'h3

// Timing
`define SCR_CLK_MHZ 250
`define SCR_CAL_2MS_US 2000
`define SCR_CAL_16MS_US 16000
`define SCR_CAL_256MS_US 256000
`define SCR_CAL_CNT_W 26

`endif

// ---- rtl/scr_cal_timer.v ----
`include "scr_defs.vh"

// Raises one calibration request on lock, then repeats at the chosen interval for codes 01, 10 and 11
module scr_cal_timer #(
    parameter CAL_CYCLES_2MS = `SCR_CAL_2MS_US * `SCR_CLK_MHZ,
    parameter CAL_CYCLES_16MS = `SCR_CAL_16MS_US * `SCR_CLK_MHZ,
    parameter CAL_CYCLES_256MS = `SCR_CAL_256MS_US * `SCR_CLK_MHZ
) (
    input wire clk_sys,
    input wire reset,
    input wire linkLocked,
    input wire [1:0] calInterval,
    output reg calRequest
);
    reg lockedPrev_q;
    reg [1:0] intervalPrev_q;
    reg [`SCR_CAL_CNT_W-1:0] count_q;
    reg [`SCR_CAL_CNT_W-1:0] period;

    // Period minus one for the selected interval
    always @* begin
        case (calInterval)
            `SCR_CAL_2MS: period = CAL_CYCLES_2MS[`SCR_CAL_CNT_W-1:0] - 1'b1;
            `SCR_CAL_16MS: period = CAL_CYCLES_16MS[`SCR_CAL_CNT_W-1:0] - 1'b1;
            `SCR_CAL_256MS: period = CAL_CYCLES_256MS[`SCR_CAL_CNT_W-1:0] - 1'b1;
            default: period = {`SCR_CAL_CNT_W{1'b0}};
        endcase
    end

    // Lock edge and interval counter; an interval change restarts the count
    always @(posedge clk_sys) begin
        if (reset) begin
            lockedPrev_q <= 1'b0;
            intervalPrev_q <= `SCR_CAL_RST;
            count_q <= {`SCR_CAL_CNT_W{1'b0}};
            calRequest <= 1'b0;
        end else begin
            lockedPrev_q <= linkLocked;
            intervalPrev_q <= calInterval;
            calRequest <= 1'b0;
            if (!linkLocked) begin
                count_q <= {`SCR_CAL_CNT_W{1'b0}};
            end else if (!lockedPrev_q) begin
                // (R10) once after lock
                calRequest <= 1'b1;
                count_q <= {`SCR_CAL_CNT_W{1'b0}};
            end else if (calInterval == `SCR_CAL_ONCE || calInterval != intervalPrev_q) begin
                count_q <= {`SCR_CAL_CNT_W{1'b0}};
            end else if (count_q == period) begin
                // (R11) periodic recalibration
                calRequest <= 1'b1;
                count_q <= {`SCR_CAL_CNT_W{1'b0}};
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end
endmodule // scr_cal_timer

// ---- rtl/scr_config_regs.v ----
`include "scr_defs.vh"

// Functional notes
// (R1) Lock bit set makes addresses own_address_and_lock through 0x1F read only.
// (R2) Register one holds peer address in bits 7:1, default 1001000, bit 0 zero.
// (R3) Spread field decodes to none, 0.5, 1.5, 2, none, 1, 3, 4 percent.
// (R4) Spread field powers up as 000 or 001 from the two strap pins.
// (R5) Register two bit four enables the audio channel, default enabled.
// (R6) Pixel range 00, 01, 10 select fixed 12.5-25, 25-50, 50-104 MHz.
// (R7) Pixel range 11, the default, selects automatic range detection.
// (R8) Rate range 00, 01, 10 select fixed 0.5-1, 1-2, 2-3.12 Gbps.
// (R9) Rate range 11, the default, selects automatic rate detection.
// (R10) Calibration field 00, the default, calibrates modulation once after lock.
// (R11) Calibration field 01, 10, 11 repeat calibration every 2, 16, 256 ms.
// (R12) Sawtooth divider zero, the default, means automatic divider calibration.
// (R13) Nonzero sawtooth divider is used as the manual divider setting.
// (R14) Register zero holds own address bits 7:1, default 1000000, lock bit 0.
// (R15) Writes under lock are dropped; stored values still read back.
module scr_config_regs #(
    parameter CAL_CYCLES_2MS = `SCR_CAL_2MS_US * `SCR_CLK_MHZ,
    parameter CAL_CYCLES_16MS = `SCR_CAL_16MS_US * `SCR_CLK_MHZ,
    parameter CAL_CYCLES_256MS = `SCR_CAL_256MS_US * `SCR_CLK_MHZ
) (
    input wire clk_sys,
    input wire reset,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData,
    output reg regRdValid,
    output wire regLockedWindow,
    input wire [1:0] spreadStrapPins,
    input wire linkLockedPin,
    output wire [6:0] ownDeviceAddress,
    output wire configWriteLock,
    output wire [6:0] peerDeviceAddress,
    output wire [2:0] spreadDepth,
    output reg [5:0] spreadTenthsPercent,
    output reg spreadActive,
    output wire audioChannelEnable,
    output wire [1:0] pixelClockRange,
    output reg pixelRangeAuto,
    output reg [10:0] pixelMinTenthsMhz,
    output reg [10:0] pixelMaxTenthsMhz,
    output wire [1:0] serialRateRange,
    output reg serialRateAuto,
    output reg [8:0] rateMinCentiGbps,
    output reg [8:0] rateMaxCentiGbps,
    output wire [1:0] modulationCalibrationInterval,
    output wire modulationCalRequest,
    output wire [5:0] sawtoothDivider,
    output reg sawtoothAuto
);
    reg [6:0] ownAddr_q;
    reg lock_q;
    reg [6:0] peerAddr_q;
    reg [2:0] spread_q;
    reg audio_q;
    reg [1:0] pixel_q;
    reg [1:0] rate_q;
    reg [1:0] calInt_q;
    reg [5:0] div_q;
    reg [1:0] strapMeta_q;
    reg [1:0] strapSync_q;
    reg lockMeta_q;
    reg lockSync_q;
    reg strapLoaded_q;
    reg [7:0] rdMux;
    wire wrAllowed;

    // Pin inputs pass two flops before any logic reads them
    always @(posedge clk_sys) begin
        strapMeta_q <= spreadStrapPins;
        strapSync_q <= strapMeta_q;
        lockMeta_q <= linkLockedPin;
        lockSync_q <= lockMeta_q;
    end

    // (R1) lock covers own_address_and_lock-0x1F
    assign regLockedWindow = lock_q && (regAddr <= `SCR_ADDR_LOCK_LAST);
    // (R15) writes dropped under lock
    assign wrAllowed = regWrEn && !regLockedWindow;

    // Register storage; the strap load on the first cycle after reset wins
    always @(posedge clk_sys) begin
        if (reset) begin
            ownAddr_q <= `SCR_OWN_ADDR_RST;
            lock_q <= `SCR_LOCK_RST;
            peerAddr_q <= `SCR_PEER_ADDR_RST;
            spread_q <= `SCR_SPREAD_OFF;
            audio_q <= `SCR_AUDIO_RST;
            pixel_q <= `SCR_PIXEL_RST;
            rate_q <= `SCR_RATE_RST;
            calInt_q <= `SCR_CAL_RST;
            div_q <= `SCR_DIV_RST;
            strapLoaded_q <= 1'b0;
        end else begin
            strapLoaded_q <= 1'b1;
            if (!strapLoaded_q) begin
                // (R4) strap picks 000 or 001
                spread_q <= (strapSync_q != 2'h0) ? `SCR_SPREAD_HALF : `SCR_SPREAD_OFF;
            end else if (wrAllowed) begin
                if (regAddr == `SCR_ADDR_OWN_LOCK) begin
                    // (R14) own address and lock bit
                    ownAddr_q <= regWrData[`SCR_OWN_ADDR_MSB:`SCR_OWN_ADDR_LSB];
                    lock_q <= regWrData[`SCR_LOCK_BIT];
                end else if (regAddr == `SCR_ADDR_PEER) begin
                    // (R2) bit 0 not stored
                    peerAddr_q <= regWrData[`SCR_OWN_ADDR_MSB:`SCR_OWN_ADDR_LSB];
                end else if (regAddr == `SCR_ADDR_SPREAD_AUDIO) begin
                    spread_q <= regWrData[`SCR_SPREAD_MSB:`SCR_SPREAD_LSB];
                    // (R5) audio enable bit
                    audio_q <= regWrData[`SCR_AUDIO_BIT];
                    pixel_q <= regWrData[`SCR_PIXEL_MSB:`SCR_PIXEL_LSB];
                    rate_q <= regWrData[`SCR_RATE_MSB:`SCR_RATE_LSB];
                end else if (regAddr == `SCR_ADDR_CAL_DIV) begin
                    calInt_q <= regWrData[`SCR_CAL_MSB:`SCR_CAL_LSB];
                    div_q <= regWrData[`SCR_DIV_MSB:`SCR_DIV_LSB];
                end
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        if (regAddr == `SCR_ADDR_OWN_LOCK) begin
            rdMux = {ownAddr_q, lock_q};
        end else if (regAddr == `SCR_ADDR_PEER) begin
            // (R2) reserved bit reads zero
            rdMux = {peerAddr_q, 1'b0};
        end else if (regAddr == `SCR_ADDR_SPREAD_AUDIO) begin
            rdMux = {spread_q, audio_q, pixel_q, rate_q};
        end else if (regAddr == `SCR_ADDR_CAL_DIV) begin
            rdMux = {calInt_q, div_q};
        end else begin
            rdMux = 8'h00;
        end
    end

    // Read data registered one cycle after the strobe
    always @(posedge clk_sys) begin
        if (reset) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                // (R15) locked values still readable
                regRdData <= rdMux;
            end
        end
    end

    // Raw field views
    assign ownDeviceAddress = ownAddr_q;
    assign configWriteLock = lock_q;
    assign peerDeviceAddress = peerAddr_q;
    assign spreadDepth = spread_q;
    assign audioChannelEnable = audio_q;
    assign pixelClockRange = pixel_q;
    assign serialRateRange = rate_q;
    assign modulationCalibrationInterval = calInt_q;
    assign sawtoothDivider = div_q;

    // Decoded settings held in flops so consumers see clean levels
    always @(posedge clk_sys) begin
        if (reset) begin
            spreadTenthsPercent <= 6'h00;
            spreadActive <= 1'b0;
            pixelRangeAuto <= 1'b1;
            pixelMinTenthsMhz <= 11'h000;
            pixelMaxTenthsMhz <= 11'h000;
            serialRateAuto <= 1'b1;
            rateMinCentiGbps <= 9'h000;
            rateMaxCentiGbps <= 9'h000;
            sawtoothAuto <= 1'b1;
        end else begin
            // (R3) spread depth decode
            case (spread_q)
                3'h1: spreadTenthsPercent <= 6'h05;
                3'h2: spreadTenthsPercent <= 6'h0f;
                3'h3: spreadTenthsPercent <= 6'h14;
                3'h5: spreadTenthsPercent <= 6'h0a;
                3'h6: spreadTenthsPercent <= 6'h1e;
                3'h7: spreadTenthsPercent <= 6'h28;
                default: spreadTenthsPercent <= 6'h00;
            endcase
            spreadActive <= (spread_q[1:0] != 2'h0);
            // (R7) pixel auto detect
            pixelRangeAuto <= (pixel_q == `SCR_RANGE_AUTO);
            // (R6) fixed pixel ranges
            case (pixel_q)
                2'h0: begin
                    pixelMinTenthsMhz <= 11'h07d;
                    pixelMaxTenthsMhz <= 11'h0fa;
                end
                2'h1: begin
                    pixelMinTenthsMhz <= 11'h0fa;
                    pixelMaxTenthsMhz <= 11'h1f4;
                end
                2'h2: begin
                    pixelMinTenthsMhz <= 11'h1f4;
                    pixelMaxTenthsMhz <= 11'h410;
                end
                default: begin
                    pixelMinTenthsMhz <= 11'h000;
                    pixelMaxTenthsMhz <= 11'h000;
                end
            endcase
            // (R9) rate auto detect
            serialRateAuto <= (rate_q == `SCR_RANGE_AUTO);
            // (R8) fixed rate ranges
            case (rate_q)
                2'h0: begin
                    rateMinCentiGbps <= 9'h032;
                    rateMaxCentiGbps <= 9'h064;
                end
                2'h1: begin
                    rateMinCentiGbps <= 9'h064;
                    rateMaxCentiGbps <= 9'h0c8;
                end
                2'h2: begin
                    rateMinCentiGbps <= 9'h0c8;
                    rateMaxCentiGbps <= 9'h138;
                end
                default: begin
                    rateMinCentiGbps <= 9'h000;
                    rateMaxCentiGbps <= 9'h000;
                end
            endcase
            // (R12) zero means auto divider
            // (R13) nonzero is manual setting
            sawtoothAuto <= (div_q == `SCR_DIV_RST);
        end
    end

    // (R10) (R11) calibration request timing
    scr_cal_timer #(
        .CAL_CYCLES_2MS(CAL_CYCLES_2MS),
        .CAL_CYCLES_16MS(CAL_CYCLES_16MS),
        .CAL_CYCLES_256MS(CAL_CYCLES_256MS)
    ) uCalTimer (
        .clk_sys(clk_sys),
        .reset(reset),
        .linkLocked(lockSync_q),
        .calInterval(calInt_q),
        .calRequest(modulationCalRequest)
    );
endmodule // scr_config_regs

// ---- dv/scr_config_regs_properties.sv ----
module scr_config_regs_properties (
    input wire clk_sys,
    input wire reset,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    input wire [7:0] regRdData,
    input wire regRdValid,
    input wire regLockedWindow,
    input wire [6:0] ownDeviceAddress,
    input wire configWriteLock,
    input wire [6:0] peerDeviceAddress,
    input wire [2:0] spreadDepth,
    input wire spreadActive,
    input wire [1:0] pixelClockRange,
    input wire pixelRangeAuto,
    input wire [1:0] serialRateRange,
    input wire serialRateAuto,
    input wire [1:0] modulationCalibrationInterval,
    input wire modulationCalRequest,
    input wire [5:0] sawtoothDivider,
    input wire sawtoothAuto
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_lock_window: assert property (regLockedWindow == (configWriteLock && regAddr <= 8'h1f))
        else $error("lock window flag wrong");
    a_locked_drop: assert property (regWrEn && regLockedWindow && regAddr == 8'h01
        |=> $stable(peerDeviceAddress)) else $error("locked write changed peer address");
    a_write_lands: assert property (regWrEn && !regLockedWindow && regAddr == 8'h03
        |=> {modulationCalibrationInterval, sawtoothDivider} == $past(regWrData))
        else $error("calibration register write lost");
    a_own_write: assert property (regWrEn && !regLockedWindow && regAddr == 8'h00
        |=> {ownDeviceAddress, configWriteLock} == $past(regWrData))
        else $error("own address register write lost");
    a_lock_sticky: assert property (configWriteLock |=> configWriteLock)
        else $error("lock bit cleared without reset");
    a_read_peer: assert property (regRdEn && regAddr == 8'h01
        |=> regRdValid && regRdData == {$past(peerDeviceAddress), 1'b0})
        else $error("peer register read wrong");
    a_spread_flag: assert property (spreadActive ==
        !($past(spreadDepth) == 3'h0 || $past(spreadDepth) == 3'h4))
        else $error("spread active flag wrong");
    a_pixel_auto: assert property (pixelRangeAuto == ($past(pixelClockRange) == 2'h3))
        else $error("pixel auto flag wrong");
    a_rate_auto: assert property (serialRateAuto == ($past(serialRateRange) == 2'h3))
        else $error("rate auto flag wrong");
    a_saw_auto: assert property (sawtoothAuto == ($past(sawtoothDivider) == 6'h00))
        else $error("divider auto flag wrong");
    a_cal_once: assert property (modulationCalRequest && modulationCalibrationInterval == 2'h0
        |=> !modulationCalRequest [*8]) else $error("repeat calibration in once mode");
endmodule // scr_config_regs_properties

bind scr_config_regs scr_config_regs_properties p_chk (.*);

// ---- dv/scr_host_model.sv ----
// Controller on the far side of the register port
module scr_host_model (
    input wire clk_sys,
    input wire [7:0] regRdData,
    input wire regRdValid,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // Write strobe; data scrambled once released so stale bytes never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    // Read strobe; answer looked at mid-cycle where it is settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        @(negedge clk_sys);
        d = regRdData;
        v = regRdValid;
    endtask
endmodule // scr_host_model

// ---- dv/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic linkLockedPin = 1'b0;
    logic [1:0] spreadStrapPins = 2'h0;
    wire [7:0] regAddr, regWrData, regRdData;
    wire regWrEn, regRdEn, regRdValid, regLockedWindow, audioChannelEnable;
    wire modulationCalRequest, sawtoothAuto;
    wire [5:0] spreadTenthsPercent;
    wire [10:0] pixelMinTenthsMhz, pixelMaxTenthsMhz;
    wire [8:0] rateMinCentiGbps, rateMaxCentiGbps;
    int n_errors = 0;
    int n_checks = 0;
    logic [10:0] pmin[4] = '{125, 250, 500, 0};
    logic [10:0] pmax[4] = '{250, 500, 1040, 0};
    logic [10:0] rmin[4] = '{50, 100, 200, 0};
    logic [10:0] rmax[4] = '{100, 200, 312, 0};
    logic [5:0] pct[8] = '{0, 5, 15, 20, 0, 10, 30, 40};
    // Short calibration periods keep the run brief
    scr_config_regs #(.CAL_CYCLES_2MS(8), .CAL_CYCLES_16MS(16), .CAL_CYCLES_256MS(32)) uut (
        .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .regLockedWindow(regLockedWindow),
        .spreadStrapPins(spreadStrapPins), .linkLockedPin(linkLockedPin),
        .ownDeviceAddress(), .configWriteLock(), .peerDeviceAddress(), .spreadDepth(),
        .spreadTenthsPercent(spreadTenthsPercent), .spreadActive(),
        .audioChannelEnable(audioChannelEnable), .pixelClockRange(), .pixelRangeAuto(),
        .pixelMinTenthsMhz(pixelMinTenthsMhz), .pixelMaxTenthsMhz(pixelMaxTenthsMhz),
        .serialRateRange(), .serialRateAuto(), .rateMinCentiGbps(rateMinCentiGbps),
        .rateMaxCentiGbps(rateMaxCentiGbps), .modulationCalibrationInterval(),
        .modulationCalRequest(modulationCalRequest), .sawtoothDivider(),
        .sawtoothAuto(sawtoothAuto));
    scr_host_model h (.clk_sys(clk_sys), .regRdData(regRdData), .regRdValid(regRdValid),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
    // 250 MHz clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        h.rd(a, d, v);
        chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
        chk("read valid", {15'h0, v}, 16'h1);
    endtask
    // Reset held twelve cycles, then two idle edges before any request
    task automatic do_reset;
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_defaults;
        rchk(8'h00, 8'h80);
        rchk(8'h01, 8'h90);
        rchk(8'h02, 8'h1f);
        rchk(8'h03, 8'h00);
        rchk(8'h07, 8'h00);
        chk("audio", {15'h0, audioChannelEnable}, 16'h1);
        $display("test defaults done");
    endtask
    task automatic t_strap;
        spreadStrapPins <= 2'h1;
        do_reset;
        rchk(8'h02, 8'h3f);
        chk("spread", {10'h0, spreadTenthsPercent}, 16'd5);
        $display("test strap done");
    endtask
    task automatic t_spread;
        for (int i = 0; i < 8; i++) begin
            h.wr(8'h02, {i[2:0], 5'h1f});
            repeat (2) @(posedge clk_sys);
            chk("spread", {10'h0, spreadTenthsPercent}, {10'h0, pct[i]});
        end
        $display("test spread done");
    endtask
    task automatic t_ranges;
        for (int i = 0; i < 4; i++) begin
            h.wr(8'h02, {4'h0, i[1:0], i[1:0]});
            repeat (2) @(posedge clk_sys);
            chk("pixel min", {5'h0, pixelMinTenthsMhz}, {5'h0, pmin[i]});
            chk("pixel max", {5'h0, pixelMaxTenthsMhz}, {5'h0, pmax[i]});
            chk("rate min", {7'h0, rateMinCentiGbps}, {5'h0, rmin[i]});
            chk("rate max", {7'h0, rateMaxCentiGbps}, {5'h0, rmax[i]});
        end
        chk("audio", {15'h0, audioChannelEnable}, 16'h0);
        $display("test ranges done");
    endtask
    // Count request pulses over a fixed window after lock rises
    task automatic count_cal(input logic [7:0] r3, output int n);
        h.wr(8'h03, r3);
        @(posedge clk_sys);
        linkLockedPin <= 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge clk_sys);
            if (modulationCalRequest === 1'b1) n++;
        end
        @(posedge clk_sys);
        linkLockedPin <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_cal;
        int n;
        count_cal(8'h40, n);
        chk("cal pulses", n[15:0], 16'd5);
        count_cal(8'h80, n);
        chk("cal pulses", n[15:0], 16'd3);
        count_cal(8'hc0, n);
        chk("cal pulses", n[15:0], 16'd2);
        count_cal(8'h05, n);
        chk("cal pulses", n[15:0], 16'd1);
        chk("divider auto", {15'h0, sawtoothAuto}, 16'h0);
        $display("test calibration done");
    endtask
    task automatic t_lock;
        h.wr(8'h01, 8'hab);
        rchk(8'h01, 8'haa);
        h.wr(8'h00, 8'h81);
        h.wr(8'h01, 8'h22);
        rchk(8'h01, 8'haa);
        h.wr(8'h00, 8'h00);
        rchk(8'h00, 8'h81);
        h.wr(8'h03, 8'hff);
        rchk(8'h03, 8'h05);
        chk("window", {15'h0, regLockedWindow}, 16'h1);
        do_reset;
        rchk(8'h00, 8'h80);
        $display("test lock done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset;
        t_defaults;
        t_strap;
        t_spread;
        t_ranges;
        t_cal;
        t_lock;
        conclude;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("ERROR run expected finish seen hang");
        conclude;
    end
endmodule // tb
